// ### core/sync_edge.v
`timescale 1ns/100ps
module sync_edge #(
    parameter W = 3
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // raw pins
    input wire [W-1:0] pin_in,
    // synchronised edges
    output wire [W-1:0] rise_pulse,
    output wire [W-1:0] fall_pulse
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;
reg [W-1:0] last_r;

// two flops against metastability, third stage only for edges
always @(posedge core_clk) begin
    if (!rst_n) begin
        meta_r <= {W{1'b0}};
        sync_r <= {W{1'b0}};
        last_r <= {W{1'b0}};
    end else begin
        meta_r <= pin_in;
        sync_r <= meta_r;
        last_r <= sync_r;
    end
end

// one-cycle pulses per edge
assign rise_pulse = sync_r & ~last_r;
assign fall_pulse = ~sync_r & last_r;

endmodule

// ### core/timer16_consts.vh
// How it works
// - ff a inverts on match a, match b, capture a or capture b, each enabled.
// - ff a software field: 00 inverts, 01 sets, 10 clears.
// - ff a drives output pin a; reset value must not be relied upon.
// - ff b inverts on match b or capture b, each with its own enable.
// - ff b software field: 00 inverts, 01 sets, 10 clears.
// - ff b drives output pin b; its reset value is undefined.
// - match irq b pulses whenever the counter reaches compare b.
// - with trigger pin a as clock source, count each rising edge.
// - pulse mode: ff a inverts on both compare matches and drives pin a.
// - double buffer on: buffer moves into compare a on match b.
// - capture mode 01: trigger a rise latches counter into capture a.
// - byte timer flipflop rise latches capture a, fall latches capture b.
// - capture mode 10: a rise to capture a, a fall to capture b, irq on fall.
// - other capture modes: external irq a fires on trigger a rising edge.
// - clear enabled: counter returns to zero on match b; else free running.
// - capture mode 11: byte timer flipflop rise to capture a, fall to b.
// - while the prescaler runs, writing zero to software capture bit latches counter into capture a.
// - double buffer on: compare a write goes to buffer only; else to both.
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// register byte offsets
`define OFS_RUN_CONTROL 8'h00
`define OFS_TIMER_MODE 8'h04
`define OFS_FF_CONTROL 8'h08
`define OFS_TRIG_CONTROL 8'h0c
`define OFS_COMPARE_A 8'h10
`define OFS_COMPARE_B 8'h14
`define OFS_CAPTURE_A 8'h18
`define OFS_CAPTURE_B 8'h1c

// run_control_reg fields
`define RUN_COUNTER_BIT 0
`define RUN_PRESCALER_BIT 1

// timer_mode_reg fields
`define MODE_CLK_LSB 0
`define MODE_CLEAR_BIT 2
`define MODE_CAP_LSB 3
`define MODE_SWCAP_BIT 5
`define MODE_B_INV_CAP_B_BIT 6
`define MODE_B_INV_MATCH_B_BIT 7

// flipflop_control_reg fields
`define FF_A_CTL_LSB 0
`define FF_B_CTL_LSB 2
`define FF_A_INV_MATCH_A_BIT 4
`define FF_A_INV_MATCH_B_BIT 5
`define FF_A_INV_CAP_A_BIT 6
`define FF_A_INV_CAP_B_BIT 7
`define FF_OUT_A_EN_BIT 8
`define FF_OUT_B_EN_BIT 9

// trigger_control_reg fields
`define TRIG_DB_EN_BIT 0

// count source codes
`define CLK_SEL_PIN 2'h0
`define CLK_SEL_TAP1 2'h1
`define CLK_SEL_TAP4 2'h2
`define CLK_SEL_TAP16 2'h3

// capture mode codes
`define CAP_OFF 2'h0
`define CAP_TIME_DIFF 2'h1
`define CAP_PULSE_WIDTH 2'h2
`define CAP_BYTE_TIMER 2'h3

// software flipflop commands
`define FF_CMD_INVERT 2'h0
`define FF_CMD_SET 2'h1
`define FF_CMD_CLEAR 2'h2
`define FF_CMD_KEEP 2'h3

// reset values
`define RST_TIMER_MODE 8'h20
`define RST_FF_CONTROL 10'h00f

`endif

// ### core/timer16_toggle_ppg_capture.v
`timescale 1ns/100ps
`include "timer16_consts.vh"
module timer16_toggle_ppg_capture #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // prescaler ticks, one cycle each
    input wire prescaler_tap_1,
    input wire prescaler_tap_4,
    input wire prescaler_tap_16,
    // trigger pins and byte timer flipflop
    input wire trigger_in_a_pin,
    input wire trigger_in_b_pin,
    input wire byte_timer_flipflop,
    // timer outputs
    output wire timer_out_a_pin,
    output wire timer_out_a_oe,
    output wire timer_out_b_pin,
    output wire timer_out_b_oe,
    // event pulses to the interrupt controller
    output reg ext_irq_a,
    output reg ext_irq_b,
    output reg match_irq_a,
    output reg match_irq_b
);

// software visible state
reg counter_run_bit_r;
reg prescaler_run_bit_r;
reg [7:0] timer_mode_reg_r;
reg [9:0] flipflop_control_reg_r;
reg double_buffer_enable_r;
reg [CNT_W-1:0] compare_reg_a_r;
reg [CNT_W-1:0] compare_buf_a_r;
reg [CNT_W-1:0] compare_reg_b_r;
reg [CNT_W-1:0] capture_reg_a_r;
reg [CNT_W-1:0] capture_reg_b_r;
reg [CNT_W-1:0] up_counter_r;
reg [CNT_W-1:0] up_counter_nxt;

// bus data phase state
reg wr_pend_r;
reg [7:0] addr_r;

// decoded fields
wire [1:0] clk_sel;
wire clear_en;
wire [1:0] capture_mode_sel;
wire ff_b_inv_on_capture_b;
wire ff_b_inv_on_match_b;
wire ff_a_inv_on_match_a;
wire ff_a_inv_on_match_b;
wire ff_a_inv_on_capture_a;
wire ff_a_inv_on_capture_b;

// edge pulses
wire [2:0] pin_rise;
wire [2:0] pin_fall;
wire trig_a_rise;
wire trig_a_fall;
wire trig_b_rise;
wire tff_rise;
wire tff_fall;

// counting and events
reg count_tick;
wire count_step;
wire clear_hit;
wire match_a;
wire match_b;
reg cap_a_hw;
reg cap_b_hw;
wire sw_capture;
wire cap_a_event;
wire cap_b_event;
wire ff_a_hw_inv;
wire ff_b_hw_inv;
wire toggle_ff_a;
wire toggle_ff_b;

// bus write strobes
wire addr_phase;
wire wr_run;
wire wr_mode;
wire wr_ff;
wire wr_trig;
wire wr_cmp_a;
wire wr_cmp_b;

assign clk_sel = timer_mode_reg_r[`MODE_CLK_LSB +: 2];
assign clear_en = timer_mode_reg_r[`MODE_CLEAR_BIT];
assign capture_mode_sel = timer_mode_reg_r[`MODE_CAP_LSB +: 2];
assign ff_b_inv_on_capture_b = timer_mode_reg_r[`MODE_B_INV_CAP_B_BIT];
assign ff_b_inv_on_match_b = timer_mode_reg_r[`MODE_B_INV_MATCH_B_BIT];
assign ff_a_inv_on_match_a = flipflop_control_reg_r[`FF_A_INV_MATCH_A_BIT];
assign ff_a_inv_on_match_b = flipflop_control_reg_r[`FF_A_INV_MATCH_B_BIT];
assign ff_a_inv_on_capture_a = flipflop_control_reg_r[`FF_A_INV_CAP_A_BIT];
assign ff_a_inv_on_capture_b = flipflop_control_reg_r[`FF_A_INV_CAP_B_BIT];

// always zero wait, always okay
assign hreadyout = 1'b1;
assign hresp = 1'b0;

// accept only whole-word transfers
assign addr_phase = hsel && htrans[1] && hready && (hsize == 3'h2);

// data phase write strobes
assign wr_run = wr_pend_r && (addr_r == `OFS_RUN_CONTROL);
assign wr_mode = wr_pend_r && (addr_r == `OFS_TIMER_MODE);
assign wr_ff = wr_pend_r && (addr_r == `OFS_FF_CONTROL);
assign wr_trig = wr_pend_r && (addr_r == `OFS_TRIG_CONTROL);
assign wr_cmp_a = wr_pend_r && (addr_r == `OFS_COMPARE_A);
assign wr_cmp_b = wr_pend_r && (addr_r == `OFS_COMPARE_B);

// the write of a zero to the capture bit is itself the trigger
assign sw_capture = wr_mode && !hwdata[`MODE_SWCAP_BIT] && prescaler_run_bit_r;

// address phase capture; reads are registered so hrdata comes from flops
always @(posedge core_clk) begin
    if (!rst_n) begin
        wr_pend_r <= 1'b0;
        addr_r <= 8'h00;
        hrdata <= 32'h00000000;
    end else begin
        wr_pend_r <= addr_phase && hwrite;
        addr_r <= haddr[7:0];
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                `OFS_RUN_CONTROL:
                    hrdata <= {30'h0, prescaler_run_bit_r, counter_run_bit_r};
                `OFS_TIMER_MODE:
                    hrdata <= {24'h0, timer_mode_reg_r};
                `OFS_FF_CONTROL:
                    hrdata <= {22'h0, flipflop_control_reg_r};
                `OFS_TRIG_CONTROL:
                    hrdata <= {31'h0, double_buffer_enable_r};
                `OFS_COMPARE_A:
                    hrdata <= {{(32-CNT_W){1'b0}}, compare_reg_a_r};
                `OFS_COMPARE_B:
                    hrdata <= {{(32-CNT_W){1'b0}}, compare_reg_b_r};
                `OFS_CAPTURE_A:
                    hrdata <= {{(32-CNT_W){1'b0}}, capture_reg_a_r};
                `OFS_CAPTURE_B:
                    hrdata <= {{(32-CNT_W){1'b0}}, capture_reg_b_r};
                default:
                    hrdata <= 32'h00000000;
            endcase
        end
    end
end

// control registers
always @(posedge core_clk) begin
    if (!rst_n) begin
        counter_run_bit_r <= 1'b0;
        prescaler_run_bit_r <= 1'b0;
        timer_mode_reg_r <= `RST_TIMER_MODE;
        flipflop_control_reg_r <= `RST_FF_CONTROL;
        double_buffer_enable_r <= 1'b0;
    end else begin
        if (wr_run) begin
            counter_run_bit_r <= hwdata[`RUN_COUNTER_BIT];
            prescaler_run_bit_r <= hwdata[`RUN_PRESCALER_BIT];
        end
        // capture bit always reads back as one
        if (wr_mode) begin
            timer_mode_reg_r <= hwdata[7:0] | (8'h01 << `MODE_SWCAP_BIT);
        end
        // command fields are one-shot and read back as keep
        if (wr_ff) begin
            flipflop_control_reg_r <= {hwdata[9:4], `FF_CMD_KEEP, `FF_CMD_KEEP};
        end
        if (wr_trig) begin
            double_buffer_enable_r <= hwdata[`TRIG_DB_EN_BIT];
        end
    end
end

// trigger a, trigger b and the byte timer flipflop share one synchroniser
sync_edge #(
    .W(3)
) u_sync_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({byte_timer_flipflop, trigger_in_b_pin, trigger_in_a_pin}),
    .rise_pulse(pin_rise),
    .fall_pulse(pin_fall)
);

assign trig_a_rise = pin_rise[0];
assign trig_a_fall = pin_fall[0];
assign trig_b_rise = pin_rise[1];
assign tff_rise = pin_rise[2];
assign tff_fall = pin_fall[2];

// count source; internal taps only move while the prescaler runs
always @* begin
    case (clk_sel)
        `CLK_SEL_PIN: count_tick = trig_a_rise;
        `CLK_SEL_TAP1: count_tick = prescaler_tap_1 && prescaler_run_bit_r;
        `CLK_SEL_TAP4: count_tick = prescaler_tap_4 && prescaler_run_bit_r;
        `CLK_SEL_TAP16: count_tick = prescaler_tap_16 && prescaler_run_bit_r;
        default: count_tick = 1'b0;
    endcase
end

assign count_step = counter_run_bit_r && count_tick;
assign clear_hit = clear_en && (up_counter_r == compare_reg_b_r);

// next counter value; wraps freely when clearing is off
always @* begin
    up_counter_nxt = up_counter_r;
    if (!counter_run_bit_r) begin
        up_counter_nxt = {CNT_W{1'b0}};
    end else if (count_step) begin
        if (clear_hit) begin
            up_counter_nxt = {CNT_W{1'b0}};
        end else begin
            up_counter_nxt = up_counter_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

always @(posedge core_clk) begin
    if (!rst_n) begin
        up_counter_r <= {CNT_W{1'b0}};
    end else begin
        up_counter_r <= up_counter_nxt;
    end
end

// a match fires once, on the step that lands on the compare value
assign match_a = count_step && (up_counter_nxt == compare_reg_a_r);
assign match_b = count_step && (up_counter_nxt == compare_reg_b_r);

// compare registers with the buffer in front of compare a
always @(posedge core_clk) begin
    if (!rst_n) begin
        compare_reg_a_r <= {CNT_W{1'b0}};
        compare_buf_a_r <= {CNT_W{1'b0}};
        compare_reg_b_r <= {CNT_W{1'b0}};
    end else begin
        if (wr_cmp_a) begin
            compare_buf_a_r <= hwdata[CNT_W-1:0];
        end
        // the buffer transfer wins over a compare a write in the same cycle, which only fills the buffer
        if (wr_cmp_a && !double_buffer_enable_r) begin
            compare_reg_a_r <= hwdata[CNT_W-1:0];
        end else if (double_buffer_enable_r && match_b) begin
            compare_reg_a_r <= compare_buf_a_r;
        end
        if (wr_cmp_b) begin
            compare_reg_b_r <= hwdata[CNT_W-1:0];
        end
    end
end

// hardware capture triggers by mode
always @* begin
    cap_a_hw = 1'b0;
    cap_b_hw = 1'b0;
    case (capture_mode_sel)
        `CAP_OFF: begin
            cap_a_hw = 1'b0;
            cap_b_hw = 1'b0;
        end
        `CAP_TIME_DIFF: begin
            cap_a_hw = trig_a_rise;
            cap_b_hw = trig_b_rise;
        end
        `CAP_PULSE_WIDTH: begin
            cap_a_hw = trig_a_rise;
            cap_b_hw = trig_a_fall;
        end
        `CAP_BYTE_TIMER: begin
            cap_a_hw = tff_rise;
            cap_b_hw = tff_fall;
        end
        default: begin
            cap_a_hw = 1'b0;
            cap_b_hw = 1'b0;
        end
    endcase
end

assign cap_a_event = cap_a_hw || sw_capture;
assign cap_b_event = cap_b_hw;

// capture latches take the counter as it stands
always @(posedge core_clk) begin
    if (!rst_n) begin
        capture_reg_a_r <= {CNT_W{1'b0}};
        capture_reg_b_r <= {CNT_W{1'b0}};
    end else begin
        if (cap_a_event) begin
            capture_reg_a_r <= up_counter_r;
        end
        if (cap_b_event) begin
            capture_reg_b_r <= up_counter_r;
        end
    end
end

// inversion sources; match a with match b gives the pulse mode
assign ff_a_hw_inv = (ff_a_inv_on_match_a && match_a) ||
    (ff_a_inv_on_match_b && match_b) ||
    (ff_a_inv_on_capture_a && cap_a_event) ||
    (ff_a_inv_on_capture_b && cap_b_event);
assign ff_b_hw_inv = (ff_b_inv_on_match_b && match_b) ||
    (ff_b_inv_on_capture_b && cap_b_event);

toggle_ff u_toggle_ff_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sw_we(wr_ff),
    .sw_cmd(hwdata[`FF_A_CTL_LSB +: 2]),
    .hw_inv(ff_a_hw_inv),
    .q_r(toggle_ff_a)
);

toggle_ff u_toggle_ff_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sw_we(wr_ff),
    .sw_cmd(hwdata[`FF_B_CTL_LSB +: 2]),
    .hw_inv(ff_b_hw_inv),
    .q_r(toggle_ff_b)
);

// pins show the flipflops; enables let the port logic take the pin
assign timer_out_a_pin = toggle_ff_a;
assign timer_out_a_oe = flipflop_control_reg_r[`FF_OUT_A_EN_BIT];
assign timer_out_b_pin = toggle_ff_b;
assign timer_out_b_oe = flipflop_control_reg_r[`FF_OUT_B_EN_BIT];

// event pulses, registered; one cycle behind the event itself
always @(posedge core_clk) begin
    if (!rst_n) begin
        ext_irq_a <= 1'b0;
        ext_irq_b <= 1'b0;
        match_irq_a <= 1'b0;
        match_irq_b <= 1'b0;
    end else begin
        if (capture_mode_sel == `CAP_PULSE_WIDTH) begin
            ext_irq_a <= trig_a_fall;
        end else begin
            ext_irq_a <= trig_a_rise;
        end
        ext_irq_b <= trig_b_rise;
        match_irq_a <= match_a;
        match_irq_b <= match_b;
    end
end

endmodule

// ### core/toggle_ff.v
`timescale 1ns/100ps
`include "timer16_consts.vh"
module toggle_ff (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // software command
    input wire sw_we,
    input wire [1:0] sw_cmd,
    // hardware inversion request
    input wire hw_inv,
    // state
    output reg q_r
);

// software command beats a hardware inversion in the same cycle
always @(posedge core_clk) begin
    if (!rst_n) begin
        q_r <= 1'b0; // defined for simulation only; users must not rely on it
    end else if (sw_we && sw_cmd != `FF_CMD_KEEP) begin
        case (sw_cmd)
            `FF_CMD_INVERT: q_r <= ~q_r;
            `FF_CMD_SET: q_r <= 1'b1;
            `FF_CMD_CLEAR: q_r <= 1'b0;
            default: q_r <= q_r;
        endcase
    end else if (hw_inv) begin
        q_r <= ~q_r;
    end
end

endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
`include "timer16_consts.vh"
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic tap_1 = 1'b0, tap_4 = 1'b0, tap_16 = 1'b0;
    logic [3:0] div_r = 4'h0;
    wire hreadyout, hresp, trig_a, trig_b, byte_ff;
    wire pin_a, oe_a, pin_b, oe_b, ext_irq_a, ext_irq_b, match_irq_a, match_irq_b;
    wire [31:0] hrdata;
    int n_mismatch = 0, n_checks = 0, n_irqa = 0;
    logic [31:0] exp_q[$], got_q[$];

    timer16_toggle_ppg_capture #(.CNT_W(16)) i_timer16_toggle_ppg_capture (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .prescaler_tap_1(tap_1), .prescaler_tap_4(tap_4), .prescaler_tap_16(tap_16),
        .trigger_in_a_pin(trig_a), .trigger_in_b_pin(trig_b),
        .byte_timer_flipflop(byte_ff), .timer_out_a_pin(pin_a), .timer_out_a_oe(oe_a),
        .timer_out_b_pin(pin_b), .timer_out_b_oe(oe_b), .ext_irq_a(ext_irq_a),
        .ext_irq_b(ext_irq_b), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
    trigger_side i_trigger_side (.core_clk(core_clk), .trigger_in_a_pin(trig_a),
        .trigger_in_b_pin(trig_b), .byte_timer_flipflop(byte_ff));

    always #10 core_clk = ~core_clk;

    // prescaler stand-in: taps every 1, 4 and 16 cycles; irq a tally
    always @(posedge core_clk) begin
        div_r <= div_r + 4'h1;
        tap_1 <= 1'b1;
        tap_4 <= (div_r[1:0] == 2'h3);
        tap_16 <= (div_r == 4'hf);
        if (ext_irq_a === 1'b1) n_irqa <= n_irqa + 1;
    end

    // oldest note against oldest result
    always @(posedge core_clk) begin
        if (got_q.size() > 0) begin
            n_checks++;
            if (got_q[0] !== exp_q[0]) begin
                n_mismatch++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got_q[0], exp_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    task see(input logic [31:0] got, input logic [31:0] exp);
        exp_q.push_back(exp);
        got_q.push_back(got);
    endtask

    // one single word transfer; entered just after an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        v = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        see(v, e);
    endtask

    task wait_mb(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (match_irq_b !== 1'b1 && c < 3000);
    endtask

    task wait_pa(input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (pin_a !== lvl && c < 3000);
    endtask

    task report_and_stop;
        repeat (2) @(posedge core_clk);
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, well beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        int c, hi, lo, st, ca, cb, d, n, i0;
        logic a0, b0;
        logic [31:0] va, vb;
        logic [1:0] cmds [4];
        cmds = '{`FF_CMD_SET, `FF_CMD_CLEAR, `FF_CMD_INVERT, `FF_CMD_INVERT};
        c = $urandom(72397);
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        // reset values, read-only and unmapped places
        rd(`OFS_TIMER_MODE, 32'h20);
        rd(`OFS_FF_CONTROL, 32'h00f);
        rd(`OFS_RUN_CONTROL, 32'h0);
        wr(`OFS_CAPTURE_A, 32'h1234);
        rd(`OFS_CAPTURE_A, 32'h0);
        rd(8'h40, 32'h0);
        $display("test reset done");
        // software commands on both flipflops, pins enabled
        st = 0;
        foreach (cmds[i]) begin
            wr(`OFS_FF_CONTROL, 32'h300 | {cmds[i], cmds[i]});
            st = (cmds[i] == `FF_CMD_SET) ? 1 : ((cmds[i] == `FF_CMD_CLEAR) ? 0 : !st);
            @(posedge core_clk);
            see({pin_a, pin_b, oe_a, oe_b}, {st[0], st[0], 2'h3});
        end
        rd(`OFS_FF_CONTROL, 32'h30f);
        $display("test ff commands done");
        // interval on each tap with clear on match b
        for (int s = 1; s < 4; s++) begin
            cb = 3 + $urandom % 20;
            wr(`OFS_RUN_CONTROL, 32'h0);
            wr(`OFS_COMPARE_B, cb);
            wr(`OFS_TIMER_MODE, 32'h24 | s);
            wr(`OFS_RUN_CONTROL, 32'h3);
            wait_mb(c);
            wait_mb(c);
            see(c, (cb + 1) << (2 * (s - 1)));
        end
        $display("test interval done");
        // event count on pin a, read back through a software capture
        n = 3 + $urandom % 6;
        i0 = n_irqa;
        wr(`OFS_RUN_CONTROL, 32'h0);
        wr(`OFS_TIMER_MODE, 32'h20);
        wr(`OFS_RUN_CONTROL, 32'h3);
        repeat (n) begin
            i_trigger_side.drive(0, 1'b1, 8);
            i_trigger_side.drive(0, 1'b0, 8);
        end
        wr(`OFS_TIMER_MODE, 32'h0);
        rd(`OFS_CAPTURE_A, n);
        see(n_irqa - i0, n);
        $display("test event count done");
        // capture modes: two events, ff inversion on captures, irq edge
        for (int m = 1; m < 4; m++) begin
            d = 10 + $urandom % 20;
            wr(`OFS_RUN_CONTROL, 32'h0);
            wr(`OFS_TIMER_MODE, 32'h61 | (m << 3));
            wr(`OFS_FF_CONTROL, 32'h3cf);
            wr(`OFS_RUN_CONTROL, 32'h3);
            i0 = n_irqa;
            a0 = pin_a;
            b0 = pin_b;
            i_trigger_side.drive((m == 3) ? 2 : 0, 1'b1, d);
            n = n_irqa - i0;
            see({n[29:0], pin_a, pin_b}, {m == 1, !a0, b0});
            i_trigger_side.drive((m == 3) ? 2 : (m == 1), m == 1, 8);
            n = n_irqa - i0;
            see({n[29:0], pin_a, pin_b}, {m != 3, a0, !b0});
            bus(1'b0, `OFS_CAPTURE_A, 32'h0, va);
            bus(1'b0, `OFS_CAPTURE_B, 32'h0, vb);
            see(vb[15:0] - va[15:0], d);
            if (m == 1) begin
                i_trigger_side.drive(0, 1'b0, 8);
                i_trigger_side.drive(1, 1'b0, 8);
            end
        end
        $display("test capture modes done");
        // pulse generation, then double buffer on compare a
        ca = 2 + $urandom % 8;
        cb = ca + 6 + $urandom % 16;
        wr(`OFS_RUN_CONTROL, 32'h0);
        wr(`OFS_COMPARE_A, ca);
        wr(`OFS_COMPARE_B, cb);
        wr(`OFS_TIMER_MODE, 32'h25);
        wr(`OFS_FF_CONTROL, 32'h13e);
        wr(`OFS_RUN_CONTROL, 32'h3);
        wait_pa(1'b1, c);
        wait_pa(1'b0, hi);
        wait_pa(1'b1, lo);
        see(match_irq_a, 1'b1);
        see(hi, cb - ca);
        see(lo, ca + 1);
        wait_mb(c);
        wr(`OFS_TRIG_CONTROL, 32'h1);
        wr(`OFS_COMPARE_A, ca + 1);
        rd(`OFS_COMPARE_A, ca);
        wait_mb(c);
        rd(`OFS_COMPARE_A, ca + 1);
        wait_pa(1'b0, c);
        wait_pa(1'b1, c);
        wait_pa(1'b0, hi);
        see(hi, cb - ca - 1);
        wr(`OFS_TRIG_CONTROL, 32'h0);
        wr(`OFS_COMPARE_A, ca);
        rd(`OFS_COMPARE_A, ca);
        // random commands while matches still invert; set and clear must win
        repeat (8) begin
            d = $urandom % 3;
            wr(`OFS_FF_CONTROL, 32'h13c | d);
            @(posedge core_clk);
            if (d != 0) see(pin_a, d == 1);
        end
        // inversion off after a match b, as a one-shot ends; pin must hold
        wait_mb(c);
        wr(`OFS_FF_CONTROL, 32'h10f);
        @(posedge core_clk);
        a0 = pin_a;
        wait_mb(c);
        see(pin_a, a0);
        $display("test pulse done");
        report_and_stop();
    end
endmodule

// ### testbench/timer16_asserts.sv
`timescale 1ns/100ps
`include "timer16_consts.vh"
module timer16_asserts #(
    parameter CNT_W = 16
) (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // bus
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    // pins and events
    input logic trigger_in_b_pin,
    input logic timer_out_a_pin,
    input logic timer_out_a_oe,
    input logic timer_out_b_pin,
    input logic timer_out_b_oe,
    input logic ext_irq_a,
    input logic ext_irq_b,
    input logic match_irq_b
);
    logic wr_r;
    logic [7:0] adr_r;
    wire ffw;

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // remember word writes so their data phase can be judged
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
        end else begin
            wr_r <= hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
        end
        adr_r <= haddr[7:0];
    end
    assign ffw = wr_r && (adr_r == `OFS_FF_CONTROL);

    // bus never stalls; irq a and match irq b are single pulses; irq b follows pin b rises; software commands win over a same-cycle inversion
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
    a_irqa_pulse: assert property (not (ext_irq_a ##1 ext_irq_a))
        else $error("ext irq a longer than one cycle");
    a_mirqb_pulse: assert property (match_irq_b |=> !match_irq_b)
        else $error("match irq b longer than one cycle");
    a_irqb_follow: assert property ($rose(trigger_in_b_pin) |-> ##[2:6] ext_irq_b)
        else $error("no ext irq b after pin b rise");
    a_irqb_quiet: assert property ($fell(trigger_in_b_pin) |-> !ext_irq_b [*6])
        else $error("ext irq b on pin b fall");
    a_ffa_set: assert property (ffw && hwdata[1:0] == 2'h1 |=> timer_out_a_pin)
        else $error("ff a not set by command");
    a_ffa_inv: assert property (ffw && hwdata[1:0] == 2'h0 |=>
        timer_out_a_pin != $past(timer_out_a_pin))
        else $error("ff a not inverted by command");
    a_ffb_clear: assert property (ffw && hwdata[3:2] == 2'h2 |=> !timer_out_b_pin)
        else $error("ff b not cleared by command");
    a_oe_follow: assert property (ffw |=> timer_out_a_oe == $past(hwdata[8]) &&
        timer_out_b_oe == $past(hwdata[9]))
        else $error("output enables do not follow write");

    c_ext_irq: cover property (ext_irq_a);
    c_interval: cover property (match_irq_b ##[2:40] match_irq_b);
    c_pin_b: cover property ($changed(timer_out_b_pin));
endmodule

bind timer16_toggle_ppg_capture timer16_asserts #(.CNT_W(CNT_W)) i_timer16_asserts (.*);

// ### testbench/trigger_side.sv
`timescale 1ns/100ps
module trigger_side (
    // clock
    input logic core_clk,
    // pins toward the timer
    output logic trigger_in_a_pin,
    output logic trigger_in_b_pin,
    output logic byte_timer_flipflop
);
    // all pins idle low
    initial begin
        trigger_in_a_pin = 1'b0;
        trigger_in_b_pin = 1'b0;
        byte_timer_flipflop = 1'b0;
    end

    // change one pin just after an edge; short levels would slip the synchroniser
    task drive(input int which, input logic lvl, input int hold);
        case (which)
            0: trigger_in_a_pin <= lvl;
            1: trigger_in_b_pin <= lvl;
            default: byte_timer_flipflop <= lvl;
        endcase
        repeat (hold < 8 ? 8 : hold) @(posedge core_clk);
    endtask
endmodule
